// *** hdl/uei_top.sv ***
// Event flags, receive shortcuts, interrupt enables and error sources of a
// DMA-backed serial port, reached over classic Wishbone.
// Assumes event pulses, bit ticks and receive status come from the datapath
// on core_clk, one cycle wide.
//
// Implementation choice: register access over Wishbone.
`timescale 1ns/1ps
`default_nettype none

// Overview of operation
// - Event flags read 1 after their event; software writes them, e.g. to clear.
// - Shortcut on: receive-buffer-full pulses the receive-start task.
// - Shortcut on: receive-buffer-full pulses the receive-stop task.
// - Enable bits exist for the four receive-side events.
// - Enable bits exist for the four transmit-side events.
// - An enable bit exists for the error event.
// - Clear alias: writing 1 clears enable bits; reads return enable state.
// - Start bit while holding register unread sets overrun.
// - Parity mismatch with checking on sets parity error.
// - Missing valid stop bit sets framing error.
// - Line low longer than a frame (10 or 11 bits) sets break.
// - Error bits read 1 while held; write 1 clears, 0 does nothing.
// - Enable register: value 8 turns the port on, 0 off.
// - Receive-buffer-full event rises when the buffer has filled.
// - Parity field 0x7 turns even parity on, 0x0 off.
module uei_top #(
  parameter int ADDR_W = uei_pkg::ADDR_W
) (
  input  wire logic              core_clk,
  input  wire logic              nrst,
  input  wire logic              wb_cyc_i,
  input  wire logic              wb_stb_i,
  input  wire logic              wb_we_i,
  input  wire logic [ADDR_W-1:0] wb_adr_i,
  input  wire logic [3:0]        wb_sel_i,
  input  wire logic [31:0]       wb_dat_i,
  output logic      [31:0]       wb_dat_o,
  output logic                   wb_ack_o,
  input  wire logic              ev_cts,
  input  wire logic              ev_clear_to_send_inactive,
  input  wire logic              ev_byte_received,
  input  wire logic              ev_rx_buffer_full,
  input  wire logic              ev_byte_sent,
  input  wire logic              ev_last_byte_transmitted,
  input  wire logic              ev_receiver_timeout,
  input  wire logic              ev_receiver_started,
  input  wire logic              ev_transmitter_started,
  input  wire logic              ev_transmitter_stopped,
  input  wire logic              rxd_in,
  input  wire logic              bit_tick,
  input  wire logic              rx_start_bit,
  input  wire logic              rx_holding_full,
  input  wire logic              rx_char_done,
  input  wire logic [7:0]        rx_data,
  input  wire logic              rx_parity_bit,
  input  wire logic              rx_stop_bit,
  output logic                   rx_start_task,
  output logic                   rx_stop_task,
  output logic                   periph_on,
  output logic                   parity_on,
  output logic                   flow_ctrl_on,
  output logic                   two_stop_bits,
  output logic                   irq
);

  // ----------------------------------------------------------------
  // Wishbone slave handshake
  // ----------------------------------------------------------------
  logic        ack_ff;
  logic        nxt_ack;
  logic [31:0] rdat_ff;
  logic [31:0] nxt_rdat;
  logic        bus_req;
  logic        wr_go;
  logic [31:0] wmask;
  logic [31:0] wval;
  logic [11:0] adr;

  assign bus_req = wb_cyc_i & wb_stb_i;
  // A write lands on the edge that the master sees ack
  assign wr_go   = bus_req & wb_we_i & ack_ff;
  assign adr     = {wb_adr_i[11:2], 2'b00};
  assign wmask   = {{8{wb_sel_i[3]}}, {8{wb_sel_i[2]}}, {8{wb_sel_i[1]}}, {8{wb_sel_i[0]}}};
  assign wval    = wb_dat_i & wmask;

  // ----------------------------------------------------------------
  // Address decode
  // ----------------------------------------------------------------
  logic       hit_evt;
  logic [4:0] evt_idx;
  logic [11:0] evt_ofs;

  assign evt_ofs = adr - uei_pkg::OFS_EVT_BASE;
  assign hit_evt = (adr >= uei_pkg::OFS_EVT_BASE) && (adr <= uei_pkg::OFS_EVT_LAST);
  assign evt_idx = evt_ofs[6:2];

  // ----------------------------------------------------------------
  // Control registers
  // ----------------------------------------------------------------
  logic [1:0]                  shortcut_control_ff;
  logic [1:0]                  nxt_shortcut_control;
  logic [uei_pkg::EVT_N-1:0]   irq_enable_ff;
  logic [uei_pkg::EVT_N-1:0]   nxt_irq_enable;
  logic [uei_pkg::EN_W-1:0]    enable_ff;
  logic [uei_pkg::EN_W-1:0]    nxt_enable;
  logic [4:0]                  config_ff;
  logic [4:0]                  nxt_config;
  logic [uei_pkg::EVT_N-1:0]   wr_irq_enable;

  // Only documented event positions carry an enable bit
  assign wr_irq_enable = wval[uei_pkg::EVT_N-1:0] & uei_pkg::EVT_MASK;

  always_comb begin
    nxt_shortcut_control = shortcut_control_ff;
    nxt_irq_enable  = irq_enable_ff;
    nxt_enable = enable_ff;
    nxt_config = config_ff;
    if (wr_go) begin
      case (adr)
        uei_pkg::OFS_SHORTCUT_CONTROL: begin
          if (wb_sel_i[0]) begin
            nxt_shortcut_control = {wb_dat_i[uei_pkg::SC_RXSTOP_BIT], wb_dat_i[uei_pkg::SC_RXSTART_BIT]};
          end
        end
        uei_pkg::OFS_IRQ_EN: begin
          nxt_irq_enable = (irq_enable_ff & ~wmask[uei_pkg::EVT_N-1:0]) | wr_irq_enable;
        end
        uei_pkg::OFS_IRQ_SET: begin
          nxt_irq_enable = irq_enable_ff | wr_irq_enable;
        end
        uei_pkg::OFS_IRQ_CLR: begin
          nxt_irq_enable = irq_enable_ff & ~wr_irq_enable;
        end
        uei_pkg::OFS_ENABLE: begin
          if (wb_sel_i[0]) begin
            nxt_enable = wb_dat_i[uei_pkg::EN_W-1:0];
          end
        end
        uei_pkg::OFS_CONFIG: begin
          if (wb_sel_i[0]) begin
            nxt_config = wb_dat_i[4:0];
          end
        end
        default: begin
          nxt_shortcut_control = shortcut_control_ff;
        end
      endcase
    end
  end

  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      shortcut_control_ff <= 2'b00;
      irq_enable_ff  <= '0;
      enable_ff <= uei_pkg::ENABLE_OFF;
      config_ff <= 5'h00;
    end else begin
      shortcut_control_ff <= nxt_shortcut_control;
      irq_enable_ff  <= nxt_irq_enable;
      enable_ff <= nxt_enable;
      config_ff <= nxt_config;
    end
  end

  // Any value other than 8 leaves the port off
  assign periph_on     = (enable_ff == uei_pkg::ENABLE_ON);
  assign parity_on     = (config_ff[uei_pkg::CFG_PAR_LSB +: 3] == uei_pkg::PARITY_EVEN);
  assign flow_ctrl_on  = config_ff[uei_pkg::CFG_HWFC_BIT];
  assign two_stop_bits = config_ff[uei_pkg::CFG_STOP_BIT];

  // ----------------------------------------------------------------
  // Error detection
  // ----------------------------------------------------------------
  logic [3:0]              brk_cnt_ff;
  logic [3:0]              nxt_brk_cnt;
  logic                    brk_done_ff;
  logic                    nxt_brk_done;
  logic [3:0]              frame_len;
  logic [uei_pkg::ERR_N-1:0] err_hit;
  logic [uei_pkg::ERR_N-1:0] err_ff;
  logic [uei_pkg::ERR_N-1:0] nxt_err;
  logic                    brk_hit;
  logic                    err_new;

  assign frame_len = parity_on ? uei_pkg::FRAME_BITS_PAR : uei_pkg::FRAME_BITS_NOPAR;
  // Break fires on the first tick past a whole frame of low line
  assign brk_hit   = periph_on & ~rxd_in & bit_tick & ~brk_done_ff & (brk_cnt_ff >= frame_len);

  always_comb begin
    nxt_brk_cnt  = brk_cnt_ff;
    nxt_brk_done = brk_done_ff;
    if (rxd_in || !periph_on) begin
      nxt_brk_cnt  = 4'h0;
      nxt_brk_done = 1'b0;
    end else if (bit_tick && !brk_done_ff) begin
      if (brk_hit) begin
        nxt_brk_done = 1'b1;
      end else begin
        nxt_brk_cnt = brk_cnt_ff + 4'h1;
      end
    end
  end

  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      brk_cnt_ff  <= 4'h0;
      brk_done_ff <= 1'b0;
    end else begin
      brk_cnt_ff  <= nxt_brk_cnt;
      brk_done_ff <= nxt_brk_done;
    end
  end

  always_comb begin
    err_hit = '0;
    err_hit[uei_pkg::ERR_OVERRUN] = periph_on & rx_start_bit & rx_holding_full;
    // Even parity: data and parity bit together hold an even count of ones
    err_hit[uei_pkg::ERR_PARITY]  = periph_on & rx_char_done & parity_on &
                                    ((^rx_data) ^ rx_parity_bit);
    err_hit[uei_pkg::ERR_FRAMING] = periph_on & rx_char_done & ~rx_stop_bit;
    err_hit[uei_pkg::ERR_BREAK]   = brk_hit;
  end

  // Detection wins over a write-one clear in the same cycle
  always_comb begin
    nxt_err = err_ff;
    if (wr_go && (adr == uei_pkg::OFS_ERR_SRC)) begin
      nxt_err = err_ff & ~wval[uei_pkg::ERR_N-1:0];
    end
    nxt_err = nxt_err | err_hit;
  end

  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      err_ff <= '0;
    end else begin
      err_ff <= nxt_err;
    end
  end

  assign err_new = |err_hit;

  // ----------------------------------------------------------------
  // Event flags
  // ----------------------------------------------------------------
  logic [uei_pkg::EVT_N-1:0] evt_set;
  logic [uei_pkg::EVT_N-1:0] evt_flag;

  always_comb begin
    evt_set = '0;
    evt_set[uei_pkg::EV_CTS]        = ev_cts;
    evt_set[uei_pkg::EV_CLEAR_TO_SEND_INACTIVE]       = ev_clear_to_send_inactive;
    evt_set[uei_pkg::EV_BYTE_RX]    = ev_byte_received;
    evt_set[uei_pkg::EV_RXBUF_FULL] = ev_rx_buffer_full;
    evt_set[uei_pkg::EV_BYTE_TX]    = ev_byte_sent;
    evt_set[uei_pkg::EV_LAST_TX]    = ev_last_byte_transmitted;
    evt_set[uei_pkg::EV_ERROR]      = err_new;
    evt_set[uei_pkg::EV_RX_TMO]     = ev_receiver_timeout;
    evt_set[uei_pkg::EV_RX_START]   = ev_receiver_started;
    evt_set[uei_pkg::EV_TX_START]   = ev_transmitter_started;
    evt_set[uei_pkg::EV_TX_STOP]    = ev_transmitter_stopped;
  end

  generate
    for (genvar gi = 0; gi < uei_pkg::EVT_N; gi++) begin : g_evt
      if (uei_pkg::EVT_MASK[gi]) begin : g_flag
        uei_evt_flag u_flag (
          .core_clk  (core_clk),
          .nrst      (nrst),
          .set_pulse (evt_set[gi]),
          .wr_en     (wr_go & hit_evt & wb_sel_i[0] & (evt_idx == 5'(gi))),
          .wr_bit    (wb_dat_i[0]),
          .flag      (evt_flag[gi])
        );
      end else begin : g_none
        assign evt_flag[gi] = 1'b0;
      end
    end
  endgenerate

  // ----------------------------------------------------------------
  // Shortcuts and interrupt line
  // ----------------------------------------------------------------
  logic rx_start_task_ff;
  logic rx_stop_task_ff;
  logic nxt_rx_start_task;
  logic nxt_rx_stop_task;

  always_comb begin
    nxt_rx_start_task = ev_rx_buffer_full & shortcut_control_ff[0];
    nxt_rx_stop_task  = ev_rx_buffer_full & shortcut_control_ff[1];
  end

  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      rx_start_task_ff <= 1'b0;
      rx_stop_task_ff  <= 1'b0;
    end else begin
      rx_start_task_ff <= nxt_rx_start_task;
      rx_stop_task_ff  <= nxt_rx_stop_task;
    end
  end

  assign rx_start_task = rx_start_task_ff;
  assign rx_stop_task  = rx_stop_task_ff;
  assign irq           = |(evt_flag & irq_enable_ff);

  // ----------------------------------------------------------------
  // Read path
  // ----------------------------------------------------------------
  always_comb begin
    nxt_rdat = uei_pkg::RESET_VAL;
    if (hit_evt) begin
      nxt_rdat[0] = evt_flag[evt_idx];
    end else begin
      case (adr)
        uei_pkg::OFS_SHORTCUT_CONTROL: begin
          nxt_rdat[uei_pkg::SC_RXSTART_BIT] = shortcut_control_ff[0];
          nxt_rdat[uei_pkg::SC_RXSTOP_BIT]  = shortcut_control_ff[1];
        end
        uei_pkg::OFS_IRQ_EN,
        uei_pkg::OFS_IRQ_SET,
        uei_pkg::OFS_IRQ_CLR: begin
          nxt_rdat[uei_pkg::EVT_N-1:0] = irq_enable_ff;
        end
        uei_pkg::OFS_ERR_SRC: begin
          nxt_rdat[uei_pkg::ERR_N-1:0] = err_ff;
        end
        uei_pkg::OFS_ENABLE: begin
          nxt_rdat[uei_pkg::EN_W-1:0] = enable_ff;
        end
        uei_pkg::OFS_CONFIG: begin
          nxt_rdat[4:0] = config_ff;
        end
        default: begin
          nxt_rdat = uei_pkg::RESET_VAL;
        end
      endcase
    end
  end

  // Ack rises one cycle after the request and drops the cycle after
  always_comb begin
    nxt_ack = bus_req & ~ack_ff;
  end

  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      ack_ff  <= 1'b0;
      rdat_ff <= uei_pkg::RESET_VAL;
    end else begin
      ack_ff  <= nxt_ack;
      rdat_ff <= (bus_req & ~ack_ff) ? nxt_rdat : rdat_ff;
    end
  end

  assign wb_ack_o = ack_ff;
  assign wb_dat_o = rdat_ff;

endmodule : uei_top
`default_nettype wire

// *** include/uei_pkg.sv ***
// Constants for the serial port event, shortcut, interrupt-enable and error-source block.
// Assumes a 32-bit classic Wishbone register bus with byte addresses.
package uei_pkg;

  // ----------------------------------------------------------------
  // Bus and address map
  // ----------------------------------------------------------------
  localparam int          ADDR_W        = 12;
  localparam logic [11:0] OFS_EVT_BASE  = 12'h100;
  localparam logic [11:0] OFS_EVT_LAST  = 12'h158;
  localparam logic [11:0] OFS_SHORTCUT_CONTROL    = 12'h200;
  localparam logic [11:0] OFS_IRQ_EN    = 12'h300;
  localparam logic [11:0] OFS_IRQ_SET   = 12'h304;
  localparam logic [11:0] OFS_IRQ_CLR   = 12'h308;
  localparam logic [11:0] OFS_ERR_SRC   = 12'h480;
  localparam logic [11:0] OFS_ENABLE    = 12'h500;
  localparam logic [11:0] OFS_CONFIG    = 12'h56c;

  // ----------------------------------------------------------------
  // Event positions: offset minus base, divided by four
  // ----------------------------------------------------------------
  localparam int          EVT_N         = 23;
  localparam logic [22:0] EVT_MASK      = 23'h5a0397;
  localparam int          EV_CTS        = 0;
  localparam int          EV_CLEAR_TO_SEND_INACTIVE       = 1;
  localparam int          EV_BYTE_RX    = 2;
  localparam int          EV_RXBUF_FULL = 4;
  localparam int          EV_BYTE_TX    = 7;
  localparam int          EV_LAST_TX    = 8;
  localparam int          EV_ERROR      = 9;
  localparam int          EV_RX_TMO     = 17;
  localparam int          EV_RX_START   = 19;
  localparam int          EV_TX_START   = 20;
  localparam int          EV_TX_STOP    = 22;

  // ----------------------------------------------------------------
  // Field layouts and values
  // ----------------------------------------------------------------
  localparam int          SC_RXSTART_BIT = 5;
  localparam int          SC_RXSTOP_BIT  = 6;
  localparam int          ERR_OVERRUN    = 0;
  localparam int          ERR_PARITY     = 1;
  localparam int          ERR_FRAMING    = 2;
  localparam int          ERR_BREAK      = 3;
  localparam int          ERR_N          = 4;
  localparam int          EN_W           = 4;
  localparam logic [3:0]  ENABLE_ON      = 4'h8;
  localparam logic [3:0]  ENABLE_OFF     = 4'h0;
  localparam int          CFG_HWFC_BIT   = 0;
  localparam int          CFG_PAR_LSB    = 1;
  localparam int          CFG_STOP_BIT   = 4;
  localparam logic [2:0]  PARITY_EVEN    = 3'h7;
  localparam logic [2:0]  PARITY_NONE    = 3'h0;
  localparam logic [31:0] RESET_VAL      = 32'h0000_0000;

  // ----------------------------------------------------------------
  // Frame lengths in bit times
  // ----------------------------------------------------------------
  localparam logic [3:0]  FRAME_BITS_NOPAR = 4'ha;
  localparam logic [3:0]  FRAME_BITS_PAR   = 4'hb;

endpackage : uei_pkg

// *** hdl/uei_evt_flag.sv ***
// One sticky event flag that hardware sets and software writes.
// Assumes single-cycle event pulses on the block clock.
`timescale 1ns/1ps
`default_nettype none

module uei_evt_flag (
  input  wire logic core_clk,
  input  wire logic nrst,
  input  wire logic set_pulse,
  input  wire logic wr_en,
  input  wire logic wr_bit,
  output logic      flag
);

  logic flag_ff;
  logic nxt_flag;

  // Set wins over a software write in the same cycle
  always_comb begin
    nxt_flag = flag_ff;
    if (wr_en) begin
      nxt_flag = wr_bit;
    end
    if (set_pulse) begin
      nxt_flag = 1'b1;
    end
  end

  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      flag_ff <= 1'b0;
    end else begin
      flag_ff <= nxt_flag;
    end
  end

  assign flag = flag_ff;

endmodule : uei_evt_flag
`default_nettype wire

// *** verif/uei_chk_sva.sv ***
// Port checker for uei_top: bus timing, shortcut tasks, irq, enables.
// Assumes one clock domain and the bind at the foot of this file.
`timescale 1ns/1ps
`default_nettype none

module uei_chk (
  input wire logic        core_clk,
  input wire logic        nrst,
  input wire logic        wb_cyc_i,
  input wire logic        wb_stb_i,
  input wire logic        wb_we_i,
  input wire logic [31:0] wb_dat_o,
  input wire logic        wb_ack_o,
  input wire logic        ev_rx_buffer_full,
  input wire logic        rx_start_task,
  input wire logic        rx_stop_task,
  input wire logic        periph_on,
  input wire logic        parity_on,
  input wire logic        irq
);
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!nrst);
  logic req_new;
  assign req_new = wb_cyc_i && wb_stb_i && !wb_ack_o;
  // --
  // Assertions
  // --
  AST_ACK_ONCE: assert property (req_new |-> ##1 wb_ack_o ##1 !wb_ack_o)
    else $error("ack not a single pulse one cycle after request");
  AST_DAT_HOLD: assert property (!wb_ack_o |-> $stable(wb_dat_o))
    else $error("read data moved outside ack");
  AST_SC_START: assert property (rx_start_task |-> $past(ev_rx_buffer_full))
    else $error("start task without buffer-full event");
  AST_SC_STOP: assert property (rx_stop_task |-> $past(ev_rx_buffer_full) ##1 !rx_stop_task)
    else $error("stop task without event or too long");
  AST_IRQ_HOLD: assert property (irq && !(wb_cyc_i && wb_we_i) |=> irq)
    else $error("irq dropped without a write");
  AST_IRQ_FALL: assert property ($fell(irq) |-> $past(wb_ack_o && wb_we_i))
    else $error("irq fell outside a write");
  AST_EN_CHANGE: assert property (!$stable(periph_on) |-> $past(wb_ack_o && wb_we_i))
    else $error("enable changed outside a write");
  AST_PAR_CHANGE: assert property ($changed(parity_on) |-> $past(wb_ack_o && wb_we_i))
    else $error("parity mode changed outside a write");
  // Main scenarios reached
  COV_BOTH_TASKS: cover property (rx_start_task && rx_stop_task);
  COV_IRQ: cover property ($rose(irq));
  COV_ON: cover property ($rose(periph_on));
endmodule : uei_chk

bind uei_top uei_chk u_chk (.core_clk(core_clk), .nrst(nrst), .wb_cyc_i(wb_cyc_i),
  .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o),
  .ev_rx_buffer_full(ev_rx_buffer_full), .rx_start_task(rx_start_task),
  .rx_stop_task(rx_stop_task), .periph_on(periph_on), .parity_on(parity_on), .irq(irq));

`default_nettype wire

// *** verif/uei_line_model.sv ***
// Remote line model: receive line level, bit ticks and receive strobes.
// Assumes its tasks are called from a single bench process.
`timescale 1ns/1ps
`default_nettype none

module uei_line_model (
  input  wire logic       core_clk,
  output var  logic       rxd_in,
  output var  logic       bit_tick,
  output var  logic       rx_start_bit,
  output var  logic       rx_holding_full,
  output var  logic       rx_char_done,
  output var  logic [7:0] rx_data,
  output var  logic       rx_parity_bit,
  output var  logic       rx_stop_bit
);
  initial begin
    rxd_in = 1'b1;
    bit_tick = 1'b0;
    rx_start_bit = 1'b0;
    rx_holding_full = 1'b0;
    rx_char_done = 1'b0;
    rx_data = 8'h5a;
    rx_parity_bit = 1'b0;
    rx_stop_bit = 1'b0;
  end
  // Ticks only inside a stretch; the tick stands still between frames
  task automatic tick(input int n);
    repeat (n) begin
      repeat (3) @(posedge core_clk);
      bit_tick <= 1'b1;
      @(posedge core_clk);
      bit_tick <= 1'b0;
    end
  endtask : tick
  // Line held low for n bit times
  task automatic brk(input int n);
    @(posedge core_clk);
    rxd_in <= 1'b0;
    tick(n);
    rxd_in <= 1'b1;
  endtask : brk
  // Even parity bit, flipped when bad is set; fields invert after the strobe
  task automatic send_char(input logic [7:0] d, input logic bad, input logic stp);
    @(posedge core_clk);
    rx_data <= d;
    rx_parity_bit <= ^d ^ bad;
    rx_stop_bit <= stp;
    rx_char_done <= 1'b1;
    @(posedge core_clk);
    rx_char_done <= 1'b0;
    rx_data <= ~d;
    rx_parity_bit <= ~(^d ^ bad);
    rx_stop_bit <= ~stp;
  endtask : send_char
  // Start bit with or without an unread character
  task automatic ovr(input logic full);
    @(posedge core_clk);
    rx_holding_full <= full;
    rx_start_bit <= 1'b1;
    @(posedge core_clk);
    rx_start_bit <= 1'b0;
    rx_holding_full <= 1'b0;
  endtask : ovr
endmodule : uei_line_model

`default_nettype wire

// *** verif/tb.sv ***
// Self-checking bench for uei_top: registers, events, shortcuts, errors.
// Assumes the checker and line model files are compiled first.
`timescale 1ns/1ps
`default_nettype none

module tb;
  logic        core_clk = 1'b0;
  logic        nrst = 1'b0;
  logic        cyc = 1'b0;
  logic        stb = 1'b0;
  logic        we = 1'b0;
  logic [11:0] adr = 12'h000;
  logic [3:0]  sel = 4'hf;
  logic [3:0]  wsel = 4'hf;
  logic        fc, tsb;
  logic [31:0] wdat = 32'h0;
  logic [31:0] rdat;
  logic        ack;
  logic [9:0]  evs = 10'h000;
  logic        rxd, tk, sb, hf, cd, pb, stp, st_t, sp_t, pon, par, irq;
  logic [7:0]  rxdat;
  logic [11:0] a;
  logic [31:0] m, d;
  logic [31:0] q[$];
  int          miscompares = 0;
  int          num_checks = 0;
  int          pos[10] = '{0, 1, 2, 4, 7, 8, 17, 19, 20, 22};
  logic [11:0] ofs[8] = '{12'h158, 12'h200, 12'h300, 12'h304, 12'h308, 12'h480, 12'h500, 12'h7f0};

  always #20 core_clk = ~core_clk;

  uei_top u_dut (.core_clk(core_clk), .nrst(nrst), .wb_cyc_i(cyc), .wb_stb_i(stb),
    .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(wdat), .wb_dat_o(rdat),
    .wb_ack_o(ack), .ev_cts(evs[0]), .ev_clear_to_send_inactive(evs[1]),
    .ev_byte_received(evs[2]), .ev_rx_buffer_full(evs[3]), .ev_byte_sent(evs[4]),
    .ev_last_byte_transmitted(evs[5]), .ev_receiver_timeout(evs[6]),
    .ev_receiver_started(evs[7]), .ev_transmitter_started(evs[8]),
    .ev_transmitter_stopped(evs[9]), .rxd_in(rxd), .bit_tick(tk), .rx_start_bit(sb),
    .rx_holding_full(hf), .rx_char_done(cd), .rx_data(rxdat), .rx_parity_bit(pb),
    .rx_stop_bit(stp), .rx_start_task(st_t), .rx_stop_task(sp_t), .periph_on(pon),
    .parity_on(par), .flow_ctrl_on(fc), .two_stop_bits(tsb), .irq(irq));

  uei_line_model u_line (.core_clk(core_clk), .rxd_in(rxd), .bit_tick(tk),
    .rx_start_bit(sb), .rx_holding_full(hf), .rx_char_done(cd), .rx_data(rxdat),
    .rx_parity_bit(pb), .rx_stop_bit(stp));

  // --
  // Shared tasks
  // --
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    num_checks++;
    if (seen !== exp) begin
      miscompares++;
      $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask : chk

  task automatic wb(input logic w, input logic [11:0] ad, input logic [31:0] dt);
    @(posedge core_clk);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= ad;
    wdat <= dt;
    sel <= wsel;
    do @(posedge core_clk); while (ack !== 1'b1);
    cyc <= 1'b0;
    stb <= 1'b0;
    we <= 1'b0;
  endtask : wb

  task automatic rd(input logic [11:0] ad, input logic [31:0] e);
    q.push_back(e);
    wb(1'b0, ad, 32'h0);
  endtask : rd

  task automatic pulse(input int k);
    @(posedge core_clk);
    evs <= 10'h001 << k;
    @(posedge core_clk);
    evs <= 10'h000;
  endtask : pulse

  task automatic complete_run;
    $display("checks %0d mismatches %0d", num_checks, miscompares);
    if (miscompares == 0 && num_checks > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask : complete_run

  // Read data is taken at the ack edge and matched to the oldest note
  always @(posedge core_clk) begin
    if (ack === 1'b1 && we === 1'b0 && q.size() > 0) chk(rdat, q.pop_front());
  end

  initial begin
    repeat (20000) @(posedge core_clk);
    miscompares++;
    complete_run();
  end

  initial begin
    void'($urandom(42078));
    repeat (2) @(posedge core_clk);
    nrst <= 1'b1;
    foreach (ofs[i]) rd(ofs[i], 32'h0);
    foreach (pos[k]) begin
      a = uei_pkg::OFS_EVT_BASE + 12'(4 * pos[k]);
      m = 32'h1 << pos[k];
      wb(1'b1, uei_pkg::OFS_IRQ_SET, m);
      rd(uei_pkg::OFS_IRQ_EN, m);
      pulse(k);
      @(negedge core_clk) chk({31'h0, irq}, 32'h1);
      rd(a, 32'h1);
      wb(1'b1, uei_pkg::OFS_IRQ_CLR, m);
      @(negedge core_clk) chk({31'h0, irq}, 32'h0);
      rd(uei_pkg::OFS_IRQ_CLR, 32'h0);
      wb(1'b1, a, 32'h0);
      rd(a, 32'h0);
    end
    d = $urandom;
    wb(1'b1, uei_pkg::OFS_IRQ_EN, d);
    rd(uei_pkg::OFS_IRQ_SET, d & 32'(uei_pkg::EVT_MASK));
    // Byte lane 0 only: the upper enable bits must survive
    wsel = 4'h1;
    wb(1'b1, uei_pkg::OFS_IRQ_EN, 32'h0);
    wsel = 4'hf;
    rd(uei_pkg::OFS_IRQ_CLR, d & 32'(uei_pkg::EVT_MASK) & 32'hffff_ff00);
    wb(1'b1, uei_pkg::OFS_IRQ_EN, 32'h0);
    for (int s = 0; s < 4; s++) begin
      wb(1'b1, uei_pkg::OFS_SHORTCUT_CONTROL, 32'(s) << uei_pkg::SC_RXSTART_BIT);
      rd(uei_pkg::OFS_SHORTCUT_CONTROL, 32'(s) << uei_pkg::SC_RXSTART_BIT);
      pulse(3);
      @(negedge core_clk) chk({30'h0, sp_t, st_t}, 32'(s));
      @(negedge core_clk) chk({30'h0, sp_t, st_t}, 32'h0);
    end
    wb(1'b1, uei_pkg::OFS_ENABLE, 32'h9);
    @(negedge core_clk) chk({31'h0, pon}, 32'h0);
    wb(1'b1, uei_pkg::OFS_ENABLE, 32'h8);
    @(negedge core_clk) chk({31'h0, pon}, 32'h1);
    wb(1'b1, uei_pkg::OFS_IRQ_SET, 32'h200);
    u_line.ovr(1'b0);
    rd(uei_pkg::OFS_ERR_SRC, 32'h0);
    u_line.ovr(1'b1);
    rd(uei_pkg::OFS_ERR_SRC, 32'h1);
    rd(12'h124, 32'h1);
    @(negedge core_clk) chk({31'h0, irq}, 32'h1);
    wb(1'b1, uei_pkg::OFS_ERR_SRC, 32'he);
    rd(uei_pkg::OFS_ERR_SRC, 32'h1);
    wb(1'b1, uei_pkg::OFS_ERR_SRC, 32'h1);
    rd(uei_pkg::OFS_ERR_SRC, 32'h0);
    u_line.send_char(d[7:0], 1'b1, 1'b1);
    rd(uei_pkg::OFS_ERR_SRC, 32'h0);
    u_line.brk(10);
    rd(uei_pkg::OFS_ERR_SRC, 32'h0);
    u_line.brk(11);
    rd(uei_pkg::OFS_ERR_SRC, 32'h8);
    wb(1'b1, uei_pkg::OFS_ERR_SRC, 32'h8);
    wb(1'b1, uei_pkg::OFS_CONFIG, 32'h1f);
    @(negedge core_clk) chk({29'h0, tsb, fc, par}, 32'h7);
    u_line.send_char(d[15:8], 1'b1, 1'b1);
    rd(uei_pkg::OFS_ERR_SRC, 32'h2);
    wb(1'b1, uei_pkg::OFS_ERR_SRC, 32'h2);
    u_line.send_char(d[23:16], 1'b0, 1'b0);
    rd(uei_pkg::OFS_ERR_SRC, 32'h4);
    wb(1'b1, uei_pkg::OFS_ERR_SRC, 32'h4);
    u_line.brk(11);
    rd(uei_pkg::OFS_ERR_SRC, 32'h0);
    u_line.brk(12);
    rd(uei_pkg::OFS_ERR_SRC, 32'h8);
    complete_run();
  end
endmodule : tb

`default_nettype wire
